// [include/ubet_pkg.sv]
// ==========================================================================
// Shared constants
package ubet_pkg;
  localparam int UBET_PCW = 32;
  // Instruction lag of an address-plus-data break, legal range 1..4
  localparam logic [2:0] UBET_DATA_LAG = 3'h2;
  localparam logic [2:0] UBET_LAG_ONE = 3'h1;
  localparam logic [2:0] UBET_LAG_MAX = 3'h4;
  localparam logic [UBET_PCW-1:0] UBET_PC_RESET = 32'h00000000;
  // Before/after select value meaning post-execution
  localparam logic UBET_SEL_POST = 1'b1;
  typedef enum {UBET_IDLE, UBET_LAG} ubet_state_t;
endpackage

// [include/ubet_mask_if.sv]
`timescale 1ns/1ps
// ==========================================================================
// Effective interrupt_mask_lock values per break kind
interface ubet_mask_if;
  logic eff_pre;
  logic eff_post;
  logic eff_opnd;
  modport prod (output eff_pre, output eff_post, output eff_opnd);
  modport cons (input eff_pre, input eff_post, input eff_opnd);
endinterface

// [src/ubet_mask.sv]
`timescale 1ns/1ps
// ==========================================================================
// Break mask evaluation
module ubet_mask
  import ubet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core status
  input wire logic retire_valid,
  input wire logic mask_before,
  input wire logic mask_after,
  input wire logic rte_slot,
  input wire logic ssr_mask,
  input wire logic exc_accepted,
  // Effective masks
  ubet_mask_if.prod m
);
  logic handler_first;
  logic next_handler_first;
  logic before_v;
  logic after_v;

  // Set on acceptance, held until the first handler instruction retires
  always_comb begin
    next_handler_first = handler_first;
    if (retire_valid) begin
      next_handler_first = 1'b0;
    end
    if (exc_accepted) begin
      next_handler_first = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      handler_first <= 1'b0;
    end else begin
      handler_first <= next_handler_first;
    end
  end

  // Return slot: before value is the return's, after value comes from status copy
  always_comb begin
    before_v = mask_before | handler_first;
    after_v = rte_slot ? ssr_mask : mask_after;
    m.eff_pre = before_v;
    m.eff_post = before_v | after_v;
    m.eff_opnd = after_v;
  end

  a_handler_mask: assert property (@(posedge clk) disable iff (srst)
    exc_accepted ##1 !exc_accepted [*1] |-> m.eff_pre)
    else $error("handler first instruction not masked");
  a_rte_slot_mask: assert property (@(posedge clk) disable iff (srst)
    rte_slot |-> m.eff_opnd == ssr_mask)
    else $error("return slot after mask wrong");
endmodule

// [src/ubet_break.sv]
`timescale 1ns/1ps
// ==========================================================================
// Break exception timing, saved_pc selection and match flags
module ubet_break
  import ubet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration bits
  input wire logic chained_mode_bit,
  input wire logic chan_a_before_after_sel,
  input wire logic chan_b_before_after_sel,
  input wire logic chan_b_data_qual,
  input wire logic flag_clear,
  // Fetch stage: confirmed fetch and instruction matches
  input wire logic fetch_confirm,
  input wire logic [UBET_PCW-1:0] fetch_pc,
  input wire logic fetch_hit_a,
  input wire logic fetch_hit_b,
  input wire logic fetch_tlb_miss,
  // Retire stage
  input wire logic retire_valid,
  input wire logic [UBET_PCW-1:0] retire_next_pc,
  input wire logic retire_hit_a,
  input wire logic retire_hit_b,
  input wire logic opnd_hit_a,
  input wire logic opnd_hit_b,
  // Core mask status
  input wire logic mask_before,
  input wire logic mask_after,
  input wire logic rte_slot,
  input wire logic ssr_mask,
  input wire logic exc_accepted,
  // Competing exceptions
  input wire logic reexec_exc,
  input wire logic completion_exc,
  input wire logic sync_exc,
  input wire logic [UBET_PCW-1:0] sync_exc_pc,
  input wire logic async_irq,
  // Break outputs
  output logic suppress_exec,
  output logic break_take,
  output logic [UBET_PCW-1:0] saved_pc,
  output logic suppress_updates,
  output logic break_vector_sel,
  output logic channel_a_hit_flag,
  output logic channel_b_hit_flag
);
  ubet_mask_if mk ();

  ubet_mask u_mask (
    .clk(clk),
    .srst(srst),
    .retire_valid(retire_valid),
    .mask_before(mask_before),
    .mask_after(mask_after),
    .rte_slot(rte_slot),
    .ssr_mask(ssr_mask),
    .exc_accepted(exc_accepted),
    .m(mk.prod)
  );

  // ========================================================================
  // Match classification
  logic pre_a;
  logic pre_b;
  logic post_a;
  logic post_b;
  logic opa_addr;
  logic opb_addr;
  logic opb_data;
  logic any_a;
  logic any_b;
  logic armed;
  logic next_armed;
  logic chain_b_ok;

  // Pre matches only count on a confirmed fetch; overrun fetches never break
  always_comb begin
    pre_a = fetch_confirm & fetch_hit_a & (chan_a_before_after_sel != UBET_SEL_POST);
    pre_b = fetch_confirm & fetch_hit_b & (chan_b_before_after_sel != UBET_SEL_POST);
    post_a = retire_valid & retire_hit_a & (chan_a_before_after_sel == UBET_SEL_POST);
    post_b = retire_valid & retire_hit_b & (chan_b_before_after_sel == UBET_SEL_POST);
    opa_addr = retire_valid & opnd_hit_a;
    opb_addr = retire_valid & opnd_hit_b & ~chan_b_data_qual;
    opb_data = retire_valid & opnd_hit_b & chan_b_data_qual;
    any_a = pre_a | post_a | opa_addr;
    any_b = pre_b | post_b | opb_addr | opb_data;
    // A registered A arms B; so do two accesses of one instruction, A then B
    chain_b_ok = chained_mode_bit & any_b & (armed | (opa_addr & opnd_hit_b));
  end

  // Sequence state: A arms, every B match clears
  always_comb begin
    next_armed = armed;
    if (!chained_mode_bit) begin
      next_armed = 1'b0;
    end else if (any_b) begin
      next_armed = 1'b0;
    end else if (any_a) begin
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

  // ========================================================================
  // Break request per kind
  logic b_ok;
  logic a_ok;
  logic pre_req;
  logic post_req;
  logic post_blocked;
  logic data_start;

  // In chained mode channel A never breaks and B needs the arm
  always_comb begin
    a_ok = ~chained_mode_bit;
    b_ok = ~chained_mode_bit | chain_b_ok;
    pre_req = ((pre_a & a_ok) | (pre_b & b_ok)) & ~mk.eff_pre;
    // Post and address-only operand breaks share the saved address
    post_req = (((post_a & a_ok) | (post_b & b_ok)) & ~mk.eff_post)
             | (((opa_addr & a_ok) | (opb_addr & b_ok)) & ~mk.eff_opnd);
    post_blocked = reexec_exc | completion_exc;
    data_start = opb_data & b_ok & ~mk.eff_opnd;
  end

  // ========================================================================
  // Lag sequencer for address-plus-data breaks
  ubet_state_t state;
  ubet_state_t next_state;
  logic [2:0] lag_cnt;
  logic [2:0] next_lag_cnt;
  logic [UBET_PCW-1:0] lag_pc;
  logic [UBET_PCW-1:0] next_lag_pc;
  logic lag_fire;
  logic lag_exc;
  logic lag_irq;

  always_comb begin
    next_state = state;
    next_lag_cnt = lag_cnt;
    next_lag_pc = lag_pc;
    lag_fire = 1'b0;
    lag_exc = 1'b0;
    lag_irq = 1'b0;
    case (state)
      UBET_IDLE: begin
        if (data_start) begin
          next_state = UBET_LAG;
          next_lag_cnt = UBET_DATA_LAG;
          next_lag_pc = retire_next_pc;
        end
      end
      UBET_LAG: begin
        if (sync_exc) begin
          lag_exc = 1'b1;
          next_state = UBET_IDLE;
        end else if (async_irq) begin
          lag_irq = 1'b1;
          next_state = UBET_IDLE;
        end else if (retire_valid) begin
          next_lag_pc = retire_next_pc;
          next_lag_cnt = lag_cnt - UBET_LAG_ONE;
          if (lag_cnt == UBET_LAG_ONE) begin
            lag_fire = 1'b1;
            next_state = UBET_IDLE;
          end
        end
      end
      default: begin
        next_state = UBET_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= UBET_IDLE;
      lag_cnt <= 3'h0;
      lag_pc <= UBET_PC_RESET;
    end else begin
      state <= next_state;
      lag_cnt <= next_lag_cnt;
      lag_pc <= next_lag_pc;
    end
  end

  // ========================================================================
  // Break arbitration and saved_pc
  logic take_now;
  logic [UBET_PCW-1:0] take_pc;
  logic take_supp;
  logic take_vec;
  logic next_break_take;
  logic [UBET_PCW-1:0] next_saved_pc;
  logic next_suppress_updates;
  logic next_break_vector_sel;

  // Lag events beat retire-stage breaks, which beat fetch-stage breaks:
  // the earliest unfinished instruction is the one whose address is saved
  always_comb begin
    take_now = 1'b0;
    take_pc = saved_pc;
    take_supp = 1'b0;
    take_vec = 1'b0;
    suppress_exec = 1'b0;
    if (lag_exc) begin
      take_now = 1'b1;
      take_pc = sync_exc_pc;
      take_supp = 1'b1;
      take_vec = 1'b1;
    end else if (lag_irq) begin
      take_now = 1'b1;
      take_pc = lag_pc;
      take_vec = 1'b1;
    end else if (lag_fire) begin
      take_now = 1'b1;
      take_pc = retire_next_pc;
      take_vec = 1'b1;
    end else if (post_req & ~post_blocked) begin
      // Core gives next_pc as target or post-slot address for delayed branches
      take_now = 1'b1;
      take_pc = retire_next_pc;
      take_vec = 1'b1;
    end else if (pre_req) begin
      // Break goes first, the translation miss is retaken on re-execution
      take_now = 1'b1;
      take_pc = fetch_pc;
      take_vec = 1'b1;
      suppress_exec = 1'b1;
    end
    next_break_take = take_now;
    next_saved_pc = take_now ? take_pc : saved_pc;
    next_suppress_updates = take_now & take_supp;
    next_break_vector_sel = take_now & take_vec;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      break_take <= 1'b0;
      saved_pc <= UBET_PC_RESET;
      suppress_updates <= 1'b0;
      break_vector_sel <= 1'b0;
    end else begin
      break_take <= next_break_take;
      saved_pc <= next_saved_pc;
      suppress_updates <= next_suppress_updates;
      break_vector_sel <= next_break_vector_sel;
    end
  end

  // ========================================================================
  // Match flags: set whatever the mask or priority outcome
  logic set_a;
  logic set_b;
  logic next_flag_a;
  logic next_flag_b;

  always_comb begin
    set_a = any_a & ~chained_mode_bit;
    // Translation miss on the fetch does not stop the flag
    set_b = (any_b & ~chained_mode_bit) | chain_b_ok;
    next_flag_a = channel_a_hit_flag;
    next_flag_b = channel_b_hit_flag;
    if (flag_clear) begin
      next_flag_a = 1'b0;
      next_flag_b = 1'b0;
    end
    // A match in the clearing cycle survives
    if (set_a) begin
      next_flag_a = 1'b1;
    end
    if (set_b) begin
      next_flag_b = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      channel_a_hit_flag <= 1'b0;
      channel_b_hit_flag <= 1'b0;
    end else begin
      channel_a_hit_flag <= next_flag_a;
      channel_b_hit_flag <= next_flag_b;
    end
  end

  // ========================================================================
  // Checks
  sequence s_pre_break;
    pre_req && !post_req && state == UBET_IDLE;
  endsequence

  sequence s_lag_exc;
    state == UBET_LAG && sync_exc;
  endsequence

  a_pre_saved_pc: assert property (@(posedge clk) disable iff (srst)
    s_pre_break |-> suppress_exec ##1 (break_take && saved_pc == $past(fetch_pc)))
    else $error("pre break pc or suppress wrong");
  a_post_saved_pc: assert property (@(posedge clk) disable iff (srst)
    (post_req && !post_blocked && state == UBET_IDLE)
    |=> break_take && saved_pc == $past(retire_next_pc))
    else $error("post break pc wrong");
  a_lag_exc_pc: assert property (@(posedge clk) disable iff (srst)
    s_lag_exc |=> break_take && suppress_updates && saved_pc == $past(sync_exc_pc))
    else $error("lag exception handling wrong");
  a_lag_irq_vec: assert property (@(posedge clk) disable iff (srst)
    (state == UBET_LAG && !sync_exc && async_irq) |=> break_take && break_vector_sel)
    else $error("interrupt in lag took vector");
  a_lag_count: assert property (@(posedge clk) disable iff (srst)
    state == UBET_LAG |-> lag_cnt >= UBET_LAG_ONE && lag_cnt <= UBET_LAG_MAX)
    else $error("lag count out of range");
  a_data_no_early: assert property (@(posedge clk) disable iff (srst)
    (state == UBET_IDLE && data_start && !post_req && !pre_req) |=> !break_take)
    else $error("data break taken without lag");
  a_blocked_flag: assert property (@(posedge clk) disable iff (srst)
    (completion_exc && post_a && !chained_mode_bit && !pre_req && state == UBET_IDLE)
    |=> !break_take && channel_a_hit_flag)
    else $error("completion clash handling wrong");
  a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
    (channel_a_hit_flag && !flag_clear) |=> channel_a_hit_flag)
    else $error("flag cleared by hardware");
  a_chain_reset: assert property (@(posedge clk) disable iff (srst)
    (chained_mode_bit && any_b) |=> !armed ##0 $stable(chained_mode_bit) [*1])
    else $error("sequence not reset by B match");
  a_masked_pre: assert property (@(posedge clk) disable iff (srst)
    (pre_a && mk.eff_pre && !post_req && !pre_b && state == UBET_IDLE) |=> !break_take)
    else $error("masked pre break taken");
  a_tlb_miss_flag: assert property (@(posedge clk) disable iff (srst)
    (pre_b && fetch_tlb_miss && !chained_mode_bit) |=> channel_b_hit_flag)
    else $error("translation miss lost the flag");
endmodule

// [verif/ubet_core_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Core pipeline model: one confirmed fetch, one retirement or one idle cycle per call
module ubet_core_model
  import ubet_pkg::*;
(
  // Clock
  input wire logic clk,
  // Fetch stage
  output logic fetch_confirm,
  output logic [UBET_PCW-1:0] fetch_pc,
  output logic fetch_hit_a,
  output logic fetch_hit_b,
  output logic fetch_tlb_miss,
  // Retire stage
  output logic retire_valid,
  output logic [UBET_PCW-1:0] retire_next_pc,
  output logic retire_hit_a,
  output logic retire_hit_b,
  output logic opnd_hit_a,
  output logic opnd_hit_b
);
  // Quiet at time zero; addresses hold junk outside their strobes
  initial begin
    {fetch_confirm, fetch_hit_a, fetch_hit_b, fetch_tlb_miss} = 4'h0;
    {retire_valid, retire_hit_a, retire_hit_b, opnd_hit_a, opnd_hit_b} = 5'h00;
    fetch_pc = 32'hA5A5A5A5;
    retire_next_pc = 32'h5A5A5A5A;
  end

  // Every task starts and ends at a falling edge
  // Stale addresses are inverted so nothing can lean on them
  task automatic idle();
    {fetch_confirm, fetch_hit_a, fetch_hit_b, fetch_tlb_miss} = 4'h0;
    {retire_valid, retire_hit_a, retire_hit_b, opnd_hit_a, opnd_hit_b} = 5'h00;
    fetch_pc = ~fetch_pc;
    retire_next_pc = ~retire_next_pc;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Confirmed fetch with its instruction matches
  task automatic fetch(input logic [UBET_PCW-1:0] pc, input logic a, b, miss);
    {fetch_confirm, fetch_hit_a, fetch_hit_b, fetch_tlb_miss} = {1'b1, a, b, miss};
    fetch_pc = pc;
    {retire_valid, retire_hit_a, retire_hit_b, opnd_hit_a, opnd_hit_b} = 5'h00;
    retire_next_pc = ~retire_next_pc;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Retirement; callers space chained instruction matches two or more apart
  // No sleep instruction is ever retired, so none carries or follows a break
  task automatic retire(input logic [UBET_PCW-1:0] npc, input logic ra, rb, oa, ob);
    {fetch_confirm, fetch_hit_a, fetch_hit_b, fetch_tlb_miss} = 4'h0;
    fetch_pc = ~fetch_pc;
    {retire_valid, retire_hit_a, retire_hit_b, opnd_hit_a, opnd_hit_b} = {1'b1, ra, rb, oa, ob};
    retire_next_pc = npc;
    @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// [verif/ubet_break_bench.sv]
`timescale 1ns/1ps
// ==========================================================================
// Break timing bench: core model drives the pipeline, bench drives status
module ubet_break_bench;
  import ubet_pkg::*;
  // Controls and core status, all changed at falling edges
  logic clk = 1'b0, srst = 1'b1, chained_mode_bit = 1'b0, chan_b_data_qual = 1'b0;
  logic chan_a_before_after_sel = 1'b0, chan_b_before_after_sel = 1'b0, flag_clear = 1'b0;
  logic mask_before = 1'b0, mask_after = 1'b0, rte_slot = 1'b0, ssr_mask = 1'b0;
  logic exc_accepted = 1'b0, reexec_exc = 1'b0, completion_exc = 1'b0, sync_exc = 1'b0;
  logic async_irq = 1'b0;
  logic [UBET_PCW-1:0] sync_exc_pc = 32'h00000000;
  // Pipeline and result nets
  logic fetch_confirm, fetch_hit_a, fetch_hit_b, fetch_tlb_miss, retire_valid;
  logic retire_hit_a, retire_hit_b, opnd_hit_a, opnd_hit_b;
  logic [UBET_PCW-1:0] fetch_pc, retire_next_pc, saved_pc;
  logic suppress_exec, break_take, suppress_updates, break_vector_sel;
  logic channel_a_hit_flag, channel_b_hit_flag;
  int errors = 0, checks_done = 0;
  // Mask cases {kind, before, after, rte_slot, ssr_mask, break expected}
  localparam logic [6:0] mtab [8] = '{7'h10, 7'h09, 7'h28, 7'h30, 7'h51, 7'h48, 7'h2D, 7'h26};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ubet_core_model u_core (.clk, .fetch_confirm, .fetch_pc, .fetch_hit_a, .fetch_hit_b,
    .fetch_tlb_miss, .retire_valid, .retire_next_pc, .retire_hit_a, .retire_hit_b,
    .opnd_hit_a, .opnd_hit_b);

  ubet_break u_dut (.clk, .srst, .chained_mode_bit, .chan_a_before_after_sel,
    .chan_b_before_after_sel, .chan_b_data_qual, .flag_clear, .fetch_confirm, .fetch_pc,
    .fetch_hit_a, .fetch_hit_b, .fetch_tlb_miss, .retire_valid, .retire_next_pc,
    .retire_hit_a, .retire_hit_b, .opnd_hit_a, .opnd_hit_b, .mask_before, .mask_after,
    .rte_slot, .ssr_mask, .exc_accepted, .reexec_exc, .completion_exc, .sync_exc,
    .sync_exc_pc, .async_irq, .suppress_exec, .break_take, .saved_pc, .suppress_updates,
    .break_vector_sel, .channel_a_hit_flag, .channel_b_hit_flag);

  // ==========================================================================
  // Comparison and sequence helpers
  task automatic chk(input logic [UBET_PCW-1:0] got, input logic [UBET_PCW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h00000000, got}, {31'h00000000, exp});
  endtask

  // Break pulse, saved address (only when a break is due) and both flags
  task automatic outs(input logic tb, input logic [UBET_PCW-1:0] pc, input logic fa, fb);
    chkb(break_take, tb);
    if (tb) chk(saved_pc, pc);
    chkb(channel_a_hit_flag, fa);
    chkb(channel_b_hit_flag, fb);
  endtask

  // Software zero write to the flags; never called twice in a row
  task automatic clr();
    flag_clear = 1'b1;
    u_core.idle();
    flag_clear = 1'b0;
  endtask

  // Channel A request of one kind: 0 pre fetch, 1 post retire, 2 operand
  task automatic kind(input logic [1:0] k, input logic [UBET_PCW-1:0] pc);
    case (k)
      2'h0: u_core.fetch(pc, 1'b1, 1'b0, 1'b0);
      2'h1: u_core.retire(pc, 1'b1, 1'b0, 1'b0, 1'b0);
      default: u_core.retire(pc, 1'b0, 1'b0, 1'b1, 1'b0);
    endcase
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Hang guard, far beyond the length of the sequence
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    outs(1'b0, UBET_PC_RESET, 1'b0, 1'b0);
    chk(saved_pc, UBET_PC_RESET);
    done("reset");
    // Pre break on B with a translation miss; suppress seen before the edge
    fork
      u_core.fetch(32'h00001000, 1'b0, 1'b1, 1'b1);
      begin
        #5;
        chkb(suppress_exec, 1'b1);
      end
    join
    outs(1'b1, 32'h00001000, 1'b0, 1'b1);
    chkb(break_vector_sel, 1'b1);
    u_core.idle();
    outs(1'b0, 32'h00001000, 1'b0, 1'b1);
    clr();
    outs(1'b0, 32'h00001000, 1'b0, 1'b0);
    done("pre");
    // Post break, then branch taken and not taken, then address-only operand
    chan_a_before_after_sel = UBET_SEL_POST;
    for (int i = 0; i < 3; i++) begin
      kind((i == 2) ? 2'h2 : 2'h1, 32'h00002000 + 32'(4 * i));
      outs(1'b1, 32'h00002000 + 32'(4 * i), 1'b1, 1'b0);
      clr();
    end
    done("post");
    // Address-plus-data break lands after the fixed lag
    chan_b_data_qual = 1'b1;
    u_core.retire(32'h00004000, 1'b0, 1'b0, 1'b0, 1'b1);
    for (int i = 1; i <= UBET_DATA_LAG; i++) begin
      chkb(break_take, 1'b0);
      u_core.retire(32'h00004000 + 32'(2 * i), 1'b0, 1'b0, 1'b0, 1'b0);
    end
    outs(1'b1, 32'h00004000 + 32'(2 * UBET_DATA_LAG), 1'b0, 1'b1);
    clr();
    // Synchronous exception inside the lag
    u_core.retire(32'h00005000, 1'b0, 1'b0, 1'b0, 1'b1);
    sync_exc = 1'b1;
    sync_exc_pc = 32'h00005800;
    u_core.idle();
    sync_exc = 1'b0;
    outs(1'b1, 32'h00005800, 1'b0, 1'b1);
    chkb(suppress_updates, 1'b1);
    clr();
    // Asynchronous interrupt inside the lag loses to the break
    u_core.retire(32'h00006000, 1'b0, 1'b0, 1'b0, 1'b1);
    async_irq = 1'b1;
    u_core.idle();
    async_irq = 1'b0;
    chan_b_data_qual = 1'b0;
    outs(1'b1, 32'h00006000, 1'b0, 1'b1);
    chkb(break_vector_sel, 1'b1);
    chkb(suppress_updates, 1'b0);
    clr();
    done("lag");
    // Mask table, return delay slot cases included
    foreach (mtab[i]) begin
      {mask_before, mask_after, rte_slot, ssr_mask} = mtab[i][4:1];
      chan_a_before_after_sel = (mtab[i][6:5] == 2'h1);
      kind(mtab[i][6:5], 32'h00003000);
      outs(mtab[i][0], 32'h00003000, 1'b1, 1'b0);
      clr();
    end
    {mask_before, mask_after, rte_slot, ssr_mask} = 4'h0;
    chan_a_before_after_sel = 1'b0;
    // First handler instruction sees the mask set; its retirement drops it
    exc_accepted = 1'b1;
    u_core.idle();
    exc_accepted = 1'b0;
    kind(2'h0, 32'h00003100);
    outs(1'b0, 32'h00003100, 1'b1, 1'b0);
    u_core.retire(32'h00003102, 1'b0, 1'b0, 1'b0, 1'b0);
    kind(2'h0, 32'h00003104);
    outs(1'b1, 32'h00003104, 1'b1, 1'b0);
    clr();
    done("mask");
    // Both channels on one instruction: one break, both flags
    {chan_a_before_after_sel, chan_b_before_after_sel} = 2'h3;
    u_core.retire(32'h00007000, 1'b1, 1'b1, 1'b0, 1'b0);
    outs(1'b1, 32'h00007000, 1'b1, 1'b1);
    u_core.idle();
    outs(1'b0, 32'h00007000, 1'b1, 1'b1);
    clr();
    // Re-execution and completion exceptions block the post break
    for (int j = 0; j < 2; j++) begin
      {reexec_exc, completion_exc} = (j == 0) ? 2'h2 : 2'h1;
      kind(2'h1, 32'h00007100);
      chkb(break_take, 1'b0);
      if (j == 1) chkb(channel_a_hit_flag, 1'b1);
      clr();
    end
    {reexec_exc, completion_exc} = 2'h0;
    done("collide");
    // Chained: instruction A, operand B two later, then a lone B
    chained_mode_bit = 1'b1;
    u_core.retire(32'h00008000, 1'b1, 1'b0, 1'b0, 1'b0);
    outs(1'b0, 32'h00008000, 1'b0, 1'b0);
    u_core.retire(32'h00008002, 1'b0, 1'b0, 1'b0, 1'b0);
    u_core.retire(32'h00008004, 1'b0, 1'b0, 1'b0, 1'b1);
    outs(1'b1, 32'h00008004, 1'b0, 1'b1);
    clr();
    u_core.retire(32'h00008100, 1'b0, 1'b0, 1'b0, 1'b1);
    outs(1'b0, 32'h00008100, 1'b0, 1'b0);
    // Two accesses of one instruction match A then B
    u_core.retire(32'h00008180, 1'b0, 1'b0, 1'b1, 1'b1);
    outs(1'b1, 32'h00008180, 1'b0, 1'b1);
    clr();
    // Operand A, instruction B four later
    u_core.retire(32'h00008200, 1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 1; i < 4; i++) begin
      u_core.retire(32'h00008200 + 32'(2 * i), 1'b0, 1'b0, 1'b0, 1'b0);
    end
    u_core.retire(32'h00008300, 1'b0, 1'b1, 1'b0, 1'b0);
    outs(1'b1, 32'h00008300, 1'b0, 1'b1);
    done("chained");
    conclude();
  end
endmodule
